// ===== design/lfs_fault_status.v
`timescale 1ns/1ps
`include "lfs_defs.vh"
module lfs_fault_status #(
  parameter NOUT = `LFS_NUM_OUT,
  parameter STAGGER = `LFS_STAGGER_CYC
) (
  input wire clock_in, // 200 MHz system clock
  input wire rst_in, // Sync reset, active high
  input wire serial_clk_in, // Serial clock pin
  input wire serial_data_in, // Serial data pin
  input wire latch_pulse_in, // Latch pin
  input wire blank_in, // Blanking pin
  input wire [NOUT-1:0] open_led_detect_in, // Open comparators
  input wire [NOUT-1:0] short_led_detect_in, // Short comparators
  input wire over_temp_in, // Above threshold
  input wire temp_recovered_in, // Below threshold minus hysteresis
  input wire sd_ready_in, // Serial data consumer ready
  output wire sd_valid_out, // Serial data bit valid
  output wire serial_data_out, // Serial data out bit
  output reg [NOUT-1:0] sink_on_out, // Driver enables, index 3n+c
  output wire [NOUT-1:0] onoff_latch_out, // On-off latch contents
  output wire [NOUT-1:0] ctrl_latch_out, // Control latch contents
  output wire overtemp_flag_out, // Overtemperature holder
  output wire thermal_shutdown_out // Drivers forced off
);
  localparam SETTLE = (`LFS_SETTLE_CYC < 1) ? 1 : `LFS_SETTLE_CYC;
  localparam SCW = 9;
  localparam IW = 5;
  localparam ST_IDLE = 1'b0;
  localparam ST_WALK = 1'b1;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  wire [3:0] pins_s;
  wire [NOUT-1:0] open_s;
  wire [NOUT-1:0] short_s;
  wire [1:0] temp_s;

  lfs_sync2 #(.W(4)) u_pins (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in({serial_clk_in, serial_data_in, latch_pulse_in, ~blank_in}),
    .q_out(pins_s)
  );

  lfs_sync2 #(.W(2 * NOUT + 2)) u_cmp (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in({open_led_detect_in, short_led_detect_in, over_temp_in, temp_recovered_in}),
    .q_out({open_s, short_s, temp_s})
  );

  wire sclk_s = pins_s[3];
  wire sdi_s = pins_s[2];
  wire lat_s = pins_s[1];
  wire blank_s = ~pins_s[0]; // Synced inverted, so reset reads as blanked
  wire otemp_s = temp_s[1];
  wire recov_s = temp_s[0];

  // ----------------------------------------
  // Edge detection
  // ----------------------------------------
  reg sclk_q;
  reg lat_q;
  reg blank_q;

  always @(posedge clock_in) begin
    if (rst_in) begin
      sclk_q <= 1'b0;
      lat_q <= 1'b0;
      blank_q <= 1'b1;
    end else begin
      sclk_q <= sclk_s;
      lat_q <= lat_s;
      blank_q <= blank_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_q;
  wire lat_rise = lat_s & ~lat_q;
  wire blank_rise = blank_s & ~blank_q;
  wire blank_fall = ~blank_s & blank_q;

  // ----------------------------------------
  // Latches and overtemperature holder
  // ----------------------------------------
  reg [`LFS_SR_W-1:0] sr_q;
  reg [NOUT-1:0] onoff_q;
  reg [NOUT-1:0] ctrl_q;
  reg otf_q;
  reg fresh_q;
  reg [NOUT-1:0] hold_q;

  wire [2:0] sel = ctrl_q[`LFS_SEL_HI:`LFS_SEL_LO];
  // Latch accepted only after a serial clock rise since the last on-off latch
  wire lat_take = lat_rise & fresh_q;

  wire [NOUT-1:0] det_raw = sel[`LFS_SEL_SHORT_BIT] ? short_s : open_s;
  wire [NOUT-1:0] det_gate = det_raw & onoff_q;

  wire [`LFS_SR_W-1:0] status_word = {otf_q, hold_q};

  always @(posedge clock_in) begin
    if (rst_in) begin
      otf_q <= 1'b0;
    end else if (otemp_s) begin
      otf_q <= 1'b1;
    end else if (lat_take && !sr_q[`LFS_SR_TOP] && recov_s) begin
      otf_q <= 1'b0;
    end
  end

  // Shutdown persists until recovered
  reg tsd_q;
  always @(posedge clock_in) begin
    if (rst_in) begin
      tsd_q <= 1'b0;
    end else if (otemp_s) begin
      tsd_q <= 1'b1;
    end else if (recov_s) begin
      tsd_q <= 1'b0;
    end
  end

  always @(posedge clock_in) begin
    if (rst_in) begin
      sr_q <= {`LFS_SR_W{1'b0}};
      onoff_q <= {NOUT{1'b0}};
      ctrl_q <= {NOUT{1'b0}};
      fresh_q <= 1'b0;
    end else if (sclk_rise) begin
      sr_q <= {sr_q[`LFS_SR_W-2:0], sdi_s};
      fresh_q <= 1'b1;
    end else if (lat_take) begin
      if (!sr_q[`LFS_SR_TOP]) begin
        onoff_q <= sr_q[NOUT-1:0];
        sr_q <= status_word;
        fresh_q <= 1'b0;
      end else begin
        ctrl_q <= sr_q[NOUT-1:0];
      end
    end
  end

  // ----------------------------------------
  // Detection holder with settle timer
  // ----------------------------------------
  reg [SCW-1:0] settle_q;
  reg [NOUT-1:0] det_last_q;

  // Restart settle timer on blank fall or result change
  always @(posedge clock_in) begin
    if (rst_in) begin
      settle_q <= {SCW{1'b0}};
      det_last_q <= {NOUT{1'b0}};
    end else begin
      det_last_q <= det_gate;
      if (blank_fall || (!blank_s && det_gate != det_last_q)) begin
        settle_q <= SETTLE[SCW-1:0];
      end else if (settle_q != {SCW{1'b0}}) begin
        settle_q <= settle_q - {{(SCW-1){1'b0}}, 1'b1};
      end
    end
  end
  // Transparent while low, frozen on rise
  always @(posedge clock_in) begin
    if (rst_in) begin
      hold_q <= {NOUT{1'b0}};
    end else if (!blank_s && !blank_rise) begin
      hold_q <= tsd_q ? {NOUT{1'b0}} : det_gate;
    end
  end

  // ----------------------------------------
  // Output stagger walker
  // ----------------------------------------
  reg st_q;
  reg [IW-1:0] idx_q;
  reg [3:0] gap_q;
  wire [NOUT-1:0] target = (blank_s | tsd_q) ? {NOUT{1'b0}} : onoff_q;

  // Walk outputs on and off in index order; shutdown clears all at once
  always @(posedge clock_in) begin
    if (rst_in) begin
      st_q <= ST_IDLE;
      idx_q <= {IW{1'b0}};
      gap_q <= 4'h0;
      sink_on_out <= {NOUT{1'b0}};
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (tsd_q) begin
            sink_on_out <= {NOUT{1'b0}};
          end else if (blank_fall || blank_rise || lat_take || (sink_on_out != target)) begin
            st_q <= ST_WALK;
            idx_q <= {IW{1'b0}};
            gap_q <= 4'h0;
          end
        end
        ST_WALK: begin
          if (tsd_q) begin
            sink_on_out <= {NOUT{1'b0}};
            st_q <= ST_IDLE;
          end else if (gap_q != 4'h0) begin
            gap_q <= gap_q - 4'h1;
          end else begin
            sink_on_out[idx_q] <= target[idx_q];
            gap_q <= STAGGER[3:0];
            if (idx_q == NOUT - 1) begin
              st_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + {{(IW-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Two-entry buffer for serial data out
  // ----------------------------------------
  reg [1:0] buf_q;
  reg [1:0] cnt_q;
  wire push = sclk_rise & (cnt_q != 2'h2);
  wire pop = sd_ready_in & (cnt_q != 2'h0);

  // Top bit pushed per serial clock rise while fewer than two held
  always @(posedge clock_in) begin
    if (rst_in) begin
      buf_q <= 2'h0;
      cnt_q <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          buf_q[cnt_q[0]] <= sr_q[`LFS_SR_TOP];
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          buf_q[0] <= buf_q[1];
          cnt_q <= cnt_q - 2'h1;
        end
        2'b11: begin
          buf_q[0] <= (cnt_q == 2'h1) ? sr_q[`LFS_SR_TOP] : buf_q[1];
          buf_q[1] <= sr_q[`LFS_SR_TOP];
        end
        default: begin
          buf_q <= buf_q;
        end
      endcase
    end
  end

  assign sd_valid_out = (cnt_q != 2'h0);
  assign serial_data_out = buf_q[0];
  assign onoff_latch_out = onoff_q;
  assign ctrl_latch_out = ctrl_q;
  assign overtemp_flag_out = otf_q;
  assign thermal_shutdown_out = tsd_q;
endmodule // lfs_fault_status

// ===== design/lfs_sync2.v
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of levels
module lfs_sync2 #(
  parameter W = 1
) (
  input wire clock_in, // Clock
  input wire rst_in, // Sync reset
  input wire [W-1:0] d_in, // Async level
  output wire [W-1:0] q_out // Synchronised level
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // Two stages; first stage read only by the second
  always @(posedge clock_in) begin
    if (rst_in) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule // lfs_sync2

// ===== shared/lfs_defs.vh
`ifndef LFS_DEFS_VH
`define LFS_DEFS_VH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define LFS_NUM_OUT 24
`define LFS_SR_W 25
`define LFS_SR_TOP 24
`define LFS_OTF_BIT 24
`define LFS_SEL_HI 23
`define LFS_SEL_LO 21
`define LFS_SEL_SHORT_BIT 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define LFS_CLK_MHZ 200
`define LFS_SETTLE_NS 1000
`define LFS_SETTLE_CYC ((`LFS_SETTLE_NS * `LFS_CLK_MHZ) / 1000)
`define LFS_STAGGER_CYC 4
`define LFS_OTEMP_TYP_C 165

`endif

// ===== tb/lfs_ctrl_model.sv
`timescale 1ns/1ps
// Controller: frame MSB first, then latch pulse
module lfs_ctrl_model (
  input wire clock_in, // Clock
  output logic sclk_out = 1'b0, // Serial clock
  output logic sdata_out = 1'b0, // Serial data
  output logic lat_out = 1'b0 // Latch
);
  task automatic send(input logic [24:0] w, input int n);
    for (int i = 24; i > 24 - n; i--) begin
      @(posedge clock_in);
      sclk_out <= 1'b0;
      sdata_out <= w[i];
      repeat (8) @(posedge clock_in);
      sclk_out <= 1'b1;
      repeat (7) @(posedge clock_in);
    end
    // Clock parks low, data shows inverse
    @(posedge clock_in);
    sclk_out <= 1'b0;
    sdata_out <= ~sdata_out;
    repeat (8) @(posedge clock_in);
    lat_out <= 1'b1;
    repeat (8) @(posedge clock_in);
    lat_out <= 1'b0;
    repeat (12) @(posedge clock_in);
  endtask
endmodule // lfs_ctrl_model

// ===== tb/lfs_fault_status_sva.sv
`timescale 1ns/1ps
// Port checks of the fault-status block
module lfs_fault_status_sva #(
  parameter NOUT = 24
) (
  input logic clock_in, // Clock
  input logic rst_in, // Reset
  input logic serial_clk_in, // Serial clock
  input logic latch_pulse_in, // Latch
  input logic blank_in, // Blank
  input logic over_temp_in, // Hot
  input logic sd_valid_out, // Buffer busy
  input logic [NOUT-1:0] sink_on_out, // Enables
  input logic [NOUT-1:0] onoff_latch_out, // On-off
  input logic [NOUT-1:0] ctrl_latch_out, // Control
  input logic overtemp_flag_out, // Flag
  input logic thermal_shutdown_out // Shutdown
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_onoff; !$stable(onoff_latch_out) |-> $past(latch_pulse_in, 2); endproperty
  a_onoff: assert property (p_onoff) else $error("onoff moved");
  property p_ctrl; !$stable(ctrl_latch_out) |-> $past(latch_pulse_in, 2); endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl moved");
  property p_push; $rose(sd_valid_out) |-> $past(serial_clk_in, 2); endproperty
  a_push: assert property (p_push) else $error("stray push");
  property p_step; !(thermal_shutdown_out || $past(thermal_shutdown_out))
    |-> $onehot0(sink_on_out ^ $past(sink_on_out)); endproperty
  a_step: assert property (p_step) else $error("two outputs moved");
  property p_blank; $rose(blank_in) |-> ##[1:150] (sink_on_out == '0); endproperty
  a_blank: assert property (p_blank) else $error("blank left outputs on");
  property p_hot; over_temp_in [*6]
    |-> ##[0:4] (overtemp_flag_out && thermal_shutdown_out); endproperty
  a_hot: assert property (p_hot) else $error("overtemp missed");
  property p_off; $rose(thermal_shutdown_out) |-> ##[0:150] (sink_on_out == '0); endproperty
  a_off: assert property (p_off) else $error("shutdown left outputs on");
  property p_clr; $fell(overtemp_flag_out) |-> $past(latch_pulse_in, 2); endproperty
  a_clr: assert property (p_clr) else $error("flag cleared early");
endmodule // lfs_fault_status_sva

bind lfs_fault_status lfs_fault_status_sva #(.NOUT(NOUT)) u_sva (.clock_in(clock_in),
  .rst_in(rst_in), .serial_clk_in(serial_clk_in), .latch_pulse_in(latch_pulse_in),
  .blank_in(blank_in), .over_temp_in(over_temp_in), .sd_valid_out(sd_valid_out),
  .sink_on_out(sink_on_out), .onoff_latch_out(onoff_latch_out),
  .ctrl_latch_out(ctrl_latch_out), .overtemp_flag_out(overtemp_flag_out),
  .thermal_shutdown_out(thermal_shutdown_out));

// ===== tb/lfs_fault_status_test.sv
`timescale 1ns/1ps
// Bench of the fault-status block
module lfs_fault_status_test;
  typedef struct packed {logic [2:0] s; logic [23:0] on; logic [24:0] ex;} lfs_row_t;
  localparam logic [24:0] ALL_ON = 25'h0FFFFFF;
  logic clock_in = 1'b0, rst_in = 1'b1, blank_in = 1'b1, over_temp_in = 1'b0;
  logic temp_recovered_in = 1'b1, sd_ready_in = 1'b1, serial_clk_in, serial_data_in;
  logic latch_pulse_in, sd_valid_out, serial_data_out, overtemp_flag_out, thermal_shutdown_out;
  logic [23:0] open_led_detect_in = 24'hA5A5A5, short_led_detect_in = 24'h5A0F3C, prev;
  logic [23:0] sink_on_out, onoff_latch_out, ctrl_latch_out;
  logic [24:0] cap = 25'h0, old, m;
  int bad_count = 0, checks = 0, n;
  lfs_row_t rows [8] = '{
    '{3'h0, 24'hFFFFFF, 25'h0A5A5A5}, '{3'h1, 24'h0F0F0F, 25'h0050505},
    '{3'h2, 24'h000000, 25'h0000000}, '{3'h3, 24'hFF00FF, 25'h0A500A5},
    '{3'h4, 24'hFFFFFF, 25'h05A0F3C}, '{3'h5, 24'hF0F0F0, 25'h0500030},
    '{3'h6, 24'h00FFFF, 25'h0000F3C}, '{3'h7, 24'h123456, 25'h0120414}};

  lfs_ctrl_model ctl (.clock_in(clock_in), .sclk_out(serial_clk_in),
    .sdata_out(serial_data_in), .lat_out(latch_pulse_in));
  lfs_fault_status uut (.clock_in(clock_in), .rst_in(rst_in), .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in), .latch_pulse_in(latch_pulse_in), .blank_in(blank_in),
    .open_led_detect_in(open_led_detect_in), .short_led_detect_in(short_led_detect_in),
    .over_temp_in(over_temp_in), .temp_recovered_in(temp_recovered_in),
    .sd_ready_in(sd_ready_in), .sd_valid_out(sd_valid_out), .serial_data_out(serial_data_out),
    .sink_on_out(sink_on_out), .onoff_latch_out(onoff_latch_out),
    .ctrl_latch_out(ctrl_latch_out), .overtemp_flag_out(overtemp_flag_out),
    .thermal_shutdown_out(thermal_shutdown_out));

  // 200 MHz clock
  always #2.5 clock_in = ~clock_in;

  // Consumer collects popped bits
  always @(posedge clock_in)
    if (sd_valid_out === 1'b1 && sd_ready_in) cap <= {cap[23:0], serial_data_out};

  // Compare and count
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    blank_in <= 1'b0;
    chk({1'b0, onoff_latch_out}, 25'h0);
    repeat (200) @(posedge clock_in);
    for (int r = 0; r < 8; r++) begin
      ctl.send({1'b1, rows[r].s, 21'h0ABCDE}, 25);
      ctl.send({1'b0, rows[r].on}, 25);
      chk(cap, {1'b1, rows[r].s, 21'h0ABCDE});
      chk({1'b0, ctrl_latch_out}, {1'b0, rows[r].s, 21'h0ABCDE});
      ctl.send({1'b0, rows[r].on}, 25);
      ctl.send({1'b0, rows[r].on}, 25);
      chk(cap, rows[r].ex);
      chk({1'b0, onoff_latch_out}, {1'b0, rows[r].on});
    end
    // Latch with no new data is ignored
    ctl.send(ALL_ON, 25);
    short_led_detect_in <= 24'h80FFFF;
    ctl.send(ALL_ON, 0);
    ctl.send(ALL_ON, 25);
    chk(cap, 25'h0120414);
    ctl.send(ALL_ON, 25);
    chk(cap, 25'h080FFFF);
    // Blank rise freezes the holder
    blank_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    short_led_detect_in <= 24'h0F0000;
    ctl.send(ALL_ON, 25);
    ctl.send(ALL_ON, 25);
    chk(cap, 25'h080FFFF);
    // Stalled consumer: two bits kept, rest refused
    old = cap;
    sd_ready_in <= 1'b0;
    ctl.send(ALL_ON, 25);
    sd_ready_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    chk(cap, {old[22:0], 2'b01});
    chk({24'h0, sd_valid_out}, 25'h0);
    // Outputs step on, then off, one at a time
    for (int d = 0; d < 2; d++) begin
      repeat (200) @(posedge clock_in);
      blank_in <= d[0];
      for (int k = 0; k < 24; k++) begin
        prev = sink_on_out;
        n = 0;
        @(negedge clock_in);
        while (sink_on_out === prev && n < 50) begin
          @(negedge clock_in);
          n++;
        end
        m = (25'h1 << (k + 1)) - 25'h1;
        chk({1'b0, sink_on_out}, (d == 1) ? (ALL_ON & ~m) : m);
      end
    end
    // Overtemperature and recovery
    @(posedge clock_in);
    blank_in <= 1'b0;
    over_temp_in <= 1'b1;
    temp_recovered_in <= 1'b0;
    repeat (200) @(posedge clock_in);
    chk({23'h0, overtemp_flag_out, thermal_shutdown_out}, 25'h3);
    chk({1'b0, sink_on_out}, 25'h0);
    ctl.send(ALL_ON, 25);
    ctl.send(ALL_ON, 25);
    chk(cap, 25'h1000000);
    over_temp_in <= 1'b0;
    temp_recovered_in <= 1'b1;
    repeat (200) @(posedge clock_in);
    chk({23'h0, overtemp_flag_out, thermal_shutdown_out}, 25'h2);
    chk({1'b0, sink_on_out}, ALL_ON);
    ctl.send(ALL_ON, 25);
    chk({24'h0, overtemp_flag_out}, 25'h0);
    complete_run();
  end
endmodule // lfs_fault_status_test
